// [hdl/gpp_port.sv]
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module gpp_port (
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  input  wire logic        hw_standby_i,
  // axi4-lite slave
  input  wire logic [17:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [17:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // bidirectional port pins 3..0
  input  wire logic [3:0]  bidir_pin_i,
  output logic      [3:0]  bidir_pin_o,
  output logic      [3:0]  bidir_pin_oe_n_o,
  output logic      [3:0]  bidir_pullup_o,
  // input-only port pins
  input  wire logic [7:0]  input_only_pin_i,
  // timer side
  input  wire logic        timer_compare_out_a_i,
  output logic             timer_capture_in_a_o,
  output logic             timer_capture_in_b_o,
  output logic             timer_external_clock_in_o,
  output logic      [3:0]  key_sense_input_o,
  // shared-address direction register of the neighbouring port
  output logic      [7:0]  shared_addr_direction_reg_o,
  output logic             shared_addr_direction_we_o
);
  import gpp_pkg::*;

  // ==========================================================
  // registers
  logic [3:0] dir_ff, latch_ff, pullup_ff, nxt_dir, nxt_latch, nxt_pullup;
  logic [2:0] tctl_ff, nxt_tctl;
  logic [7:0] shdir_ff, nxt_shdir;
  logic       shdir_we_ff, nxt_shdir_we;
  logic [3:0] pin_s;
  logic [7:0] p7_s;

  gpp_sync #(.W(4)) u_sync_p6 (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .async_i   (bidir_pin_i),
    .sync_o    (pin_s)
  );
  gpp_sync #(.W(8)) u_sync_p7 (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .async_i   (input_only_pin_i),
    .sync_o    (p7_s)
  );

  // ==========================================================
  // axi write channel
  logic        aw_ff, w_ff, bv_ff, nxt_aw, nxt_w, nxt_bv;
  logic [17:0] awa_ff, nxt_awa;
  logic [31:0] wd_ff, nxt_wd;
  logic [3:0]  wd_strb_ff, nxt_wd_strb;
  logic [1:0]  br_ff, nxt_br;
  logic        do_wr;
  logic [3:0]  wdata4;

  assign s_axi_awready = !aw_ff && !bv_ff;
  assign s_axi_wready  = !w_ff && !bv_ff;
  assign do_wr  = aw_ff && w_ff && !bv_ff;
  assign wdata4 = wd_ff[3:0];

  always_comb begin
    nxt_aw = aw_ff;  nxt_w = w_ff;  nxt_bv = bv_ff;
    nxt_awa = awa_ff;  nxt_wd = wd_ff;  nxt_br = br_ff;
    nxt_dir = dir_ff;  nxt_latch = latch_ff;  nxt_pullup = pullup_ff;
    nxt_tctl = tctl_ff;  nxt_shdir = shdir_ff;  nxt_shdir_we = 1'b0;
    nxt_wd_strb = wd_strb_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw = 1'b1;
      nxt_awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w = 1'b1;
      nxt_wd = s_axi_wdata;
      nxt_wd_strb = s_axi_wstrb;
    end
    if (do_wr) begin
      nxt_aw = 1'b0;
      nxt_w  = 1'b0;
      nxt_bv = 1'b1;
      nxt_br = RESP_OKAY;
      if (wd_strb_ff[0]) begin
        unique case (awa_ff[17:2])
          ADDR_P6_DIR:    nxt_dir = wdata4;
          ADDR_P6_LATCH:  nxt_latch = wdata4;
          ADDR_P6_PULLUP: nxt_pullup = wdata4;
          ADDR_TIMER_CTL: nxt_tctl = wd_ff[2:0];
          ADDR_P7_LEVELS: begin
            nxt_shdir = wd_ff[7:0];
            nxt_shdir_we = 1'b1;
          end
          default: nxt_br = RESP_SLVERR;
        endcase
      end
    end
    if (bv_ff && s_axi_bready) begin
      nxt_bv = 1'b0;
    end
    if (hw_standby_i) begin
      nxt_pullup = RESET_BYTE[3:0];
      nxt_dir    = RESET_BYTE[3:0];
      nxt_latch  = RESET_BYTE[3:0];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      aw_ff <= 1'b0;  w_ff <= 1'b0;  bv_ff <= 1'b0;
      awa_ff <= '0;  wd_ff <= '0;  br_ff <= RESP_OKAY;
      wd_strb_ff <= '0;
      dir_ff <= RESET_BYTE[3:0];
      latch_ff <= RESET_BYTE[3:0];
      pullup_ff <= RESET_BYTE[3:0];
      tctl_ff <= '0;
      shdir_ff <= RESET_BYTE;
      shdir_we_ff <= 1'b0;
    end else begin
      aw_ff <= nxt_aw;  w_ff <= nxt_w;  bv_ff <= nxt_bv;
      awa_ff <= nxt_awa;  wd_ff <= nxt_wd;  br_ff <= nxt_br;
      wd_strb_ff <= nxt_wd_strb;
      dir_ff <= nxt_dir;
      latch_ff <= nxt_latch;
      pullup_ff <= nxt_pullup;
      tctl_ff <= nxt_tctl;
      shdir_ff <= nxt_shdir;
      shdir_we_ff <= nxt_shdir_we;
    end
  end

  assign s_axi_bvalid = bv_ff;
  assign s_axi_bresp  = br_ff;
  assign shared_addr_direction_reg_o = shdir_ff;
  assign shared_addr_direction_we_o  = shdir_we_ff;

  // ==========================================================
  // pin muxing
  logic cmp_a_oe;
  logic [3:0] drive_en, drive_val;
  assign cmp_a_oe = tctl_ff[TIMER_CMPA_OE_BIT];

  always_comb begin
    drive_val = latch_ff;
    drive_en  = dir_ff;
    if (cmp_a_oe) begin
      drive_en[1]  = 1'b1;
      drive_val[1] = timer_compare_out_a_i;
    end
  end

  assign bidir_pullup_o   = pullup_ff & ~dir_ff;
  assign bidir_pin_o      = drive_val;
  assign bidir_pin_oe_n_o = ~drive_en;

  assign timer_capture_in_b_o = pin_s[3];
  assign timer_capture_in_a_o = pin_s[2];
  assign timer_external_clock_in_o =
    (tctl_ff[TIMER_CKS_LSB +: 2] == CKS_EXTERNAL) ? pin_s[0] : 1'b0;
  assign key_sense_input_o = pin_s;

  // ==========================================================
  // axi read channel
  logic        rv_ff, nxt_rv;
  logic [31:0] rd_ff, nxt_rd;
  logic [1:0]  rr_ff, nxt_rr;
  assign s_axi_arready = !rv_ff;

  always_comb begin
    nxt_rv = rv_ff;  nxt_rd = rd_ff;  nxt_rr = rr_ff;
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rv = 1'b1;
      nxt_rd = '0;
      nxt_rr = RESP_OKAY;
      unique case (s_axi_araddr[17:2])
        ADDR_P6_DIR:    nxt_rd[3:0] = dir_ff;
        // latch for outputs, pin for inputs
        ADDR_P6_LATCH:  nxt_rd[3:0] = (dir_ff & latch_ff) | (~dir_ff & pin_s);
        ADDR_P6_PULLUP: nxt_rd[3:0] = pullup_ff;
        ADDR_TIMER_CTL: nxt_rd[2:0] = tctl_ff;
        ADDR_P7_LEVELS: nxt_rd[7:0] = p7_s;
        default: nxt_rr = RESP_SLVERR;
      endcase
    end else if (rv_ff && s_axi_rready) begin
      nxt_rv = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rv_ff <= 1'b0;
      rd_ff <= '0;
      rr_ff <= RESP_OKAY;
    end else begin
      rv_ff <= nxt_rv;
      rd_ff <= nxt_rd;
      rr_ff <= nxt_rr;
    end
  end

  assign s_axi_rvalid = rv_ff;
  assign s_axi_rdata  = rd_ff;
  assign s_axi_rresp  = rr_ff;
endmodule
`default_nettype wire

// [hdl/gpp_pkg.sv]
`default_nettype none
package gpp_pkg;
  // register indices: the bus byte address is four times the index
  localparam logic [15:0] ADDR_P6_DIR    = 16'hffb0;
  localparam logic [15:0] ADDR_P6_LATCH  = 16'hffb4;
  localparam logic [15:0] ADDR_P6_PULLUP = 16'hffb8;
  localparam logic [15:0] ADDR_P7_LEVELS = 16'hffbe;
  localparam logic [15:0] ADDR_TIMER_CTL = 16'hffc0;
  localparam int          TIMER_CMPA_OE_BIT = 0;
  localparam int          TIMER_CKS_LSB  = 1;
  localparam logic [1:0]  CKS_EXTERNAL   = 2'h3;
  localparam logic [7:0]  RESET_BYTE     = 8'h00;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  localparam int          SYNC_STAGES    = 3;
endpackage
`default_nettype wire

// [hdl/gpp_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// three-stage pin synchroniser; change accepted when stages two and three agree
module gpp_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_sys_i,
  input  wire logic         srst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  import gpp_pkg::*;
  logic [W-1:0] s1_ff, s2_ff, s3_ff, out_ff;
  logic [W-1:0] nxt_out;

  always_comb begin
    nxt_out = out_ff;
    for (int i = 0; i < W; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_out[i] = s3_ff[i];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      s1_ff  <= '0;
      s2_ff  <= '0;
      s3_ff  <= '0;
      out_ff <= '0;
    end else begin
      s1_ff  <= async_i;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign sync_o = out_ff;
endmodule
`default_nettype wire

// [tb/gpp_pins.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========
// far-side pins and compare source
module gpp_pins (
  input  wire logic       clk_sys_i,
  input  wire logic [3:0] drv_i,
  input  wire logic [3:0] oe_n_i,
  input  wire logic [3:0] pull_i,
  input  wire logic [3:0] ext_i,
  input  wire logic [3:0] ext_en_i,
  output logic      [3:0] level_o,
  output logic            cmp_o
);
  logic [3:0] junk = 4'h5;
  logic       cmp  = 1'b0;
  // released, unpulled pins wander so a stale value cannot pass
  always @(posedge clk_sys_i) begin
    junk <= ~junk;
    cmp  <= ~cmp;
  end
  assign cmp_o = cmp;
  assign level_o = (~oe_n_i & drv_i) | (oe_n_i & ext_en_i & ext_i) | (oe_n_i & ~ext_en_i & (pull_i | junk));
endmodule
`default_nettype wire

// [tb/gpp_port_chk.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========
// port checker
module gpp_port_chk (
  input wire logic       clk_sys_i,
  input wire logic       srst_i,
  input wire logic       hw_standby_i,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [3:0] bidir_pin_i,
  input wire logic [3:0] bidir_pin_oe_n_o,
  input wire logic [3:0] bidir_pullup_o,
  input wire logic       timer_capture_in_a_o,
  input wire logic       timer_capture_in_b_o,
  input wire logic       timer_external_clock_in_o,
  input wire logic [3:0] key_sense_input_o,
  input wire logic       shared_addr_direction_we_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  sequence pins_quiet;
    $stable(bidir_pin_i) [*8];
  endsequence
  // bit1 excluded: a compare output may drive while direction is input
  pull_off_a: assert property ((bidir_pullup_o & ~bidir_pin_oe_n_o & 4'hd) == 4'h0) else $error("pullup while driving");
  standby_off_a: assert property (hw_standby_i |=> bidir_pullup_o == 4'h0) else $error("pullup in standby");
  key_follow_a: assert property (pins_quiet |-> key_sense_input_o == bidir_pin_i) else $error("key sense stale");
  cap_a_a: assert property (pins_quiet |-> timer_capture_in_a_o == bidir_pin_i[2])
    else $error("capture a not pin2");
  cap_b_a: assert property (pins_quiet |-> timer_capture_in_b_o == bidir_pin_i[3])
    else $error("capture b not pin3");
  ext_clk_a: assert property (timer_external_clock_in_o |-> key_sense_input_o[0]) else $error("ext clock not pin0");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  we_pulse_a: assert property (shared_addr_direction_we_o |=> !shared_addr_direction_we_o) else $error("we too long");
endmodule
bind gpp_port gpp_port_chk u_chk (
  .clk_sys_i                  (clk_sys_i),
  .srst_i                     (srst_i),
  .hw_standby_i               (hw_standby_i),
  .s_axi_bresp                (s_axi_bresp),
  .s_axi_bvalid               (s_axi_bvalid),
  .s_axi_bready               (s_axi_bready),
  .bidir_pin_i                (bidir_pin_i),
  .bidir_pin_oe_n_o           (bidir_pin_oe_n_o),
  .bidir_pullup_o             (bidir_pullup_o),
  .timer_capture_in_a_o       (timer_capture_in_a_o),
  .timer_capture_in_b_o       (timer_capture_in_b_o),
  .timer_external_clock_in_o  (timer_external_clock_in_o),
  .key_sense_input_o          (key_sense_input_o),
  .shared_addr_direction_we_o (shared_addr_direction_we_o)
);
`default_nettype wire

// [tb/gpp_port_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module gpp_port_tb;
  import gpp_pkg::*;
  logic clk_sys_i = 0, srst_i = 1, hw_standby_i = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, cmp, tclk, sh_we, cap_a, cap_b;
  logic [17:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [3:0] pin, drv, oe_n, pull, key, ext = 0, ext_en = 0, m, e, wstrb = 4'hf;
  logic [7:0] inp = 0, shdir, dir, lat, pu;
  int error_cnt = 0, checked = 0, seed = 19422;
  always #12.5 clk_sys_i = ~clk_sys_i;
  gpp_port DUT (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .hw_standby_i(hw_standby_i), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .bidir_pin_i(pin), .bidir_pin_o(drv), .bidir_pin_oe_n_o(oe_n), .bidir_pullup_o(pull),
    .input_only_pin_i(inp), .timer_compare_out_a_i(cmp), .timer_capture_in_a_o(cap_a), .timer_capture_in_b_o(cap_b),
    .timer_external_clock_in_o(tclk), .key_sense_input_o(key), .shared_addr_direction_reg_o(shdir),
    .shared_addr_direction_we_o(sh_we));
  gpp_pins u_pins (.clk_sys_i(clk_sys_i), .drv_i(drv), .oe_n_i(oe_n), .pull_i(pull), .ext_i(ext),
    .ext_en_i(ext_en), .level_o(pin), .cmp_o(cmp));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask
  // level the far side shows: own drive, else external source, else the pull-up
  function automatic logic [3:0] pin_level(input logic [3:0] dr, lt, pl, x, xe);
    return (dr & lt) | (~dr & ((xe & x) | (~xe & pl)));
  endfunction
  task automatic wr(input logic [15:0] a, input logic [31:0] v, input logic [3:0] s = 4'hf);
    @(posedge clk_sys_i);
    awaddr <= {a, 2'b00}; wdata <= v; wstrb <= s; awv <= 1; wv <= 1; bready <= 1;
    do begin
      @(posedge clk_sys_i);
      if (awready) awv <= 0;
      if (wready) wv <= 0;
    end while (!bvalid);
    bready <= 0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk_sys_i);
    araddr <= {a, 2'b00}; arv <= 1; rready <= 1;
    do begin
      @(posedge clk_sys_i);
      if (arready) arv <= 0;
    end while (!rvalid);
    d = rdata; r = rresp; rready <= 0;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #300us;
    error_cnt++;
    conclude;
  end
  initial begin
    repeat (4) @(posedge clk_sys_i);
    srst_i <= 0;
    rd(ADDR_P6_DIR); chk("dir rst", d, 0);
    rd(ADDR_P6_PULLUP); chk("pullup rst", d, 0);
    for (int i = 0; i < 10; i++) begin
      {dir, lat, pu} = 24'($random(seed));
      wr(ADDR_P6_DIR, dir); wr(ADDR_P6_LATCH, lat); wr(ADDR_P6_PULLUP, pu);
      {ext, ext_en, inp} <= 16'($random(seed));
      repeat (8) @(posedge clk_sys_i);
      chk("pullup", pull, pu[3:0] & ~dir[3:0]);
      chk("oe_n", oe_n, 4'(~dir[3:0]));
      chk("drive", drv | oe_n, 4'(lat[3:0] | ~dir[3:0]));
      m = dir[3:0] | ext_en | pu[3:0];
      e = pin_level(dir[3:0], lat[3:0], pu[3:0], ext, ext_en);
      chk("key", key & m & ~dir[3:0], e & m & ~dir[3:0]);
      rd(ADDR_P6_LATCH); chk("port read", d[3:0] & m, e & m);
      rd(ADDR_P7_LEVELS); chk("levels", d, {24'h0, inp});
    end
    wr(ADDR_P7_LEVELS, 32'ha5); chk("shared dir", shdir, 8'ha5);
    rd(ADDR_P7_LEVELS); chk("levels kept", d, {24'h0, inp});
    rd(16'hff00); chk("unmapped", r, RESP_SLVERR);
    wr(ADDR_P6_DIR, 0); ext_en <= 4'hf; ext <= 4'h1;
    // low byte lane off: the write must leave the register alone
    wr(ADDR_P6_DIR, 32'hf, 4'he);
    rd(ADDR_P6_DIR); chk("strobe off", d, 0);
    wr(ADDR_TIMER_CTL, 32'h7);
    repeat (8) @(negedge clk_sys_i);
    chk("oe bit1", oe_n[1], 0);
    chk("cmp out", drv[1], cmp);
    chk("ext clk", tclk, 1);
    wr(ADDR_TIMER_CTL, 0);
    repeat (2) @(negedge clk_sys_i);
    chk("ext clk off", tclk, 0);
    wr(ADDR_P6_PULLUP, 32'hff);
    @(posedge clk_sys_i) hw_standby_i <= 1;
    @(posedge clk_sys_i) hw_standby_i <= 0;
    rd(ADDR_P6_PULLUP); chk("standby", d, 0);
    wr(ADDR_P6_PULLUP, 32'hf);
    srst_i <= 1;
    repeat (2) @(posedge clk_sys_i);
    srst_i <= 0;
    rd(ADDR_P6_PULLUP); chk("pullup rst mid", d, 0);
    chk("pull pins rst", pull, 0);
    conclude;
  end
endmodule
`default_nettype wire
